// ===== sem_host.sv
// host controller driving one port of a dual-port flag space
// assumes: device pins are asynchronous; user logic shares i_clk
`timescale 1ns/1ps
module sem_host (
  input  wire logic                               i_clk,
  input  wire logic                               i_srst,
  input  wire logic                               i_cmd_valid,
  input  wire sem_host_pkg::cmd_s                 i_cmd,
  output logic                                    o_cmd_ready,
  output logic                                    o_done,
  output logic                                    o_granted,
  output logic                                    o_flag,
  output logic                                    o_flag_space_select_n,
  output logic                                    o_array_select_n,
  output logic                                    o_oe_n,
  output logic                                    o_rw_n,
  output logic [sem_host_pkg::IDX_W-1:0]          o_flag_index_lines,
  output logic [sem_host_pkg::DATA_W-1:0]         o_data,
  output logic                                    o_data_oe,
  input  wire logic [sem_host_pkg::DATA_W-1:0]    i_data
);

  // -------------------------------------------------------------------------
  // pin synchroniser and state
  // -------------------------------------------------------------------------
  logic [sem_host_pkg::DATA_W-1:0] data_sync;
  sem_host_pkg::ctl_s              ctl_reg;
  sem_host_pkg::ctl_s              ctl_next;

  sem_sync2 #(
    .WIDTH (sem_host_pkg::DATA_W)
  ) u_data_sync (
    .i_clk   (i_clk),
    .i_async (i_data),
    .o_sync  (data_sync)
  );

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  // open one flag-space access; array select never drops
  function automatic sem_host_pkg::ctl_s start_access(
    input sem_host_pkg::ctl_s                   s,
    input logic                                 wr,
    input logic                                 val,
    input logic [sem_host_pkg::IDX_W-1:0]       idx
  );
    sem_host_pkg::ctl_s t;
    t                          = s;
    t.st                       = wr ? sem_host_pkg::ST_WRITE
                                    : sem_host_pkg::ST_READ;
    t.cnt                      = sem_host_pkg::PULSE_LD;
    t.last_rd                  = ~wr;
    t.pins                     = sem_host_pkg::PINS_IDLE;
    t.pins.flag_space_select_n = 1'b0;
    t.pins.rw_n                = ~wr;
    t.pins.oe_n                = wr;
    t.pins.data_oe             = wr;
    t.pins.data_out            = {sem_host_pkg::DATA_W{val}};
    t.pins.flag_index_lines    = idx;
    return t;
  endfunction

  // end the command and hand the port back
  function automatic sem_host_pkg::ctl_s finish(
    input sem_host_pkg::ctl_s s,
    input logic               grant
  );
    sem_host_pkg::ctl_s t;
    t         = s;
    t.st      = sem_host_pkg::ST_IDLE;
    t.ready   = 1'b1;
    t.done    = 1'b1;
    t.granted = grant;
    return t;
  endfunction

  // -------------------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------------------
  always_comb begin
    ctl_next      = ctl_reg;
    ctl_next.done = 1'b0;
    unique case (ctl_reg.st)
      // free every flag and clear our request latches after reset
      sem_host_pkg::ST_BOOT: begin
        ctl_next    = start_access(ctl_reg, 1'b1, 1'b1,
                                   sem_host_pkg::IDX_FIRST);
        ctl_next.op = sem_host_pkg::CMD_INIT;
      end
      sem_host_pkg::ST_IDLE: begin
        if (i_cmd_valid) begin
          ctl_next.ready   = 1'b0;
          ctl_next.failed  = 1'b0;
          ctl_next.granted = 1'b0;
          unique case (i_cmd.op)
            // claim opens with the zero write, never with a read
            sem_host_pkg::CMD_CLAIM:
              ctl_next = start_access(ctl_next, 1'b1, 1'b0,
                                      i_cmd.idx);
            sem_host_pkg::CMD_RELEASE:
              ctl_next = start_access(ctl_next, 1'b1, 1'b1,
                                      i_cmd.idx);
            sem_host_pkg::CMD_READ:
              ctl_next = start_access(ctl_next, 1'b0, 1'b0, i_cmd.idx);
            sem_host_pkg::CMD_INIT:
              ctl_next = start_access(ctl_next, 1'b1, 1'b1,
                                      sem_host_pkg::IDX_FIRST);
          endcase
          ctl_next.op = i_cmd.op;
        end
      end
      // hold the strobe, then return all strobes high
      sem_host_pkg::ST_WRITE,
      sem_host_pkg::ST_READ: begin
        if (ctl_reg.cnt == sem_host_pkg::CNT_ZERO) begin
          if (ctl_reg.st == sem_host_pkg::ST_READ) begin
            ctl_next.flag = data_sync[0];  // all bits carry the flag
          end
          ctl_next.pins.flag_space_select_n = 1'b1;
          ctl_next.pins.oe_n                = 1'b1;
          ctl_next.pins.rw_n                = 1'b1;
          ctl_next.pins.data_oe             = 1'b0;
          ctl_next.st                       = sem_host_pkg::ST_GAP;
          ctl_next.cnt                      = sem_host_pkg::GAP_LD;
        end else begin
          ctl_next.cnt = ctl_reg.cnt - sem_host_pkg::CNT_ONE;
        end
      end
      // after the gap decide the next access of the command
      sem_host_pkg::ST_GAP: begin
        if (ctl_reg.cnt != sem_host_pkg::CNT_ZERO) begin
          ctl_next.cnt = ctl_reg.cnt - sem_host_pkg::CNT_ONE;
        end else begin
          unique case (ctl_reg.op)
            sem_host_pkg::CMD_CLAIM: begin
              if (ctl_reg.failed) begin
                ctl_next = finish(ctl_reg, 1'b0);
              end else if (!ctl_reg.last_rd) begin
                ctl_next = start_access(ctl_reg, 1'b0, 1'b0,
                  ctl_reg.pins.flag_index_lines);
              end else if (!ctl_reg.flag) begin
                ctl_next = finish(ctl_reg, 1'b1);
              end else begin
                // withdraw so a stale request cannot seize it later
                ctl_next = start_access(ctl_reg, 1'b1, 1'b1,
                  ctl_reg.pins.flag_index_lines);
                ctl_next.failed = 1'b1;
              end
            end
            sem_host_pkg::CMD_INIT: begin
              if (ctl_reg.pins.flag_index_lines == sem_host_pkg::IDX_LAST)
              begin
                ctl_next = finish(ctl_reg, 1'b0);
              end else begin
                ctl_next = start_access(ctl_reg, 1'b1, 1'b1,
                  ctl_reg.pins.flag_index_lines
                  + sem_host_pkg::IDX_STEP);
              end
            end
            default: begin
              ctl_next = finish(ctl_reg, 1'b0);
            end
          endcase
        end
      end
      default: begin
        ctl_next = sem_host_pkg::CTL_RESET;
      end
    endcase
  end

  // -------------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctl_reg <= sem_host_pkg::CTL_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // outputs straight from the state register
  assign o_cmd_ready           = ctl_reg.ready;
  assign o_done                = ctl_reg.done;
  assign o_granted             = ctl_reg.granted;
  assign o_flag                = ctl_reg.flag;
  assign o_flag_space_select_n = ctl_reg.pins.flag_space_select_n;
  assign o_array_select_n      = ctl_reg.pins.array_select_n;
  assign o_oe_n                = ctl_reg.pins.oe_n;
  assign o_rw_n                = ctl_reg.pins.rw_n;
  assign o_flag_index_lines    = ctl_reg.pins.flag_index_lines;
  assign o_data                = ctl_reg.pins.data_out;
  assign o_data_oe             = ctl_reg.pins.data_oe;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  logic claim_take;
  logic release_take;
  logic fail_seen;
  assign claim_take   = ctl_reg.st == sem_host_pkg::ST_IDLE && i_cmd_valid
                        && i_cmd.op == sem_host_pkg::CMD_CLAIM;
  assign release_take = ctl_reg.st == sem_host_pkg::ST_IDLE && i_cmd_valid
                        && i_cmd.op == sem_host_pkg::CMD_RELEASE;
  assign fail_seen    = ctl_reg.st == sem_host_pkg::ST_READ
                        && ctl_reg.cnt == sem_host_pkg::CNT_ZERO
                        && ctl_reg.op == sem_host_pkg::CMD_CLAIM
                        && data_sync[0] && !ctl_reg.failed;

  sequence s_zero_write;
    !o_flag_space_select_n && !o_rw_n && o_data_oe && !o_data[0];
  endsequence

  sequence s_read_strobe;
    !o_flag_space_select_n && !o_oe_n && o_rw_n && !o_data_oe;
  endsequence

  AST_ARRAY_IDLE: assert property (@(posedge i_clk) disable iff (i_srst)
    o_array_select_n) else $error("array select driven low");
  AST_SEL_GAP: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(o_flag_space_select_n) |-> o_flag_space_select_n [*4])
    else $error("flag select reasserted without a gap");
  AST_WR_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
    ($fell(o_flag_space_select_n) && !o_rw_n)
      |-> (!o_flag_space_select_n && !o_rw_n && o_data_oe) [*8])
    else $error("write strobe cut short");
  AST_CLAIM_WR_FIRST: assert property (@(posedge i_clk)
    disable iff (i_srst) claim_take |=> s_zero_write)
    else $error("claim did not start with a zero write");
  AST_CLAIM_RD_NEXT: assert property (@(posedge i_clk)
    disable iff (i_srst) claim_take |=> s_zero_write ##[1:20] s_read_strobe)
    else $error("claim readback missing");
  AST_WITHDRAW: assert property (@(posedge i_clk) disable iff (i_srst)
    fail_seen |-> ##[1:10] (!o_rw_n && o_data[0] && o_data_oe))
    else $error("failed claim not withdrawn");
  AST_RELEASE_ONE: assert property (@(posedge i_clk)
    disable iff (i_srst) release_take |=> (!o_rw_n && o_data[0]))
    else $error("release did not write one");
  AST_BOOT_INIT: assert property (@(posedge i_clk)
    disable iff (i_srst) $fell(i_srst) |-> ##[1:2]
      (!o_rw_n && o_data[0]
       && o_flag_index_lines == sem_host_pkg::IDX_FIRST))
    else $error("start-up free write missing");
  AST_GRANT_ZERO: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_done && o_granted) |-> !o_flag)
    else $error("grant without zero readback");

endmodule

// ===== sem_host_pkg.sv
// constants and types for the host side of a dual-port flag-space controller
// assumes: one 200 MHz clock, synchronous active-high reset
package sem_host_pkg;

  // -------------------------------------------------------------------------
  // pin widths and flag index
  // -------------------------------------------------------------------------
  localparam int          DATA_W      = 8;
  localparam int          IDX_W       = 3;
  localparam logic [2:0]  IDX_FIRST   = 3'h0;
  localparam logic [2:0]  IDX_LAST    = 3'h7;
  localparam logic [2:0]  IDX_STEP    = 3'h1;
  localparam int          SYNC_STAGES = 2;

  // -------------------------------------------------------------------------
  // timing: access time of the flag space and idle gap between accesses
  // -------------------------------------------------------------------------
  localparam int CLK_NS      = 5;
  localparam int T_ACCESS_NS = 40;  // plain default, slowest expected part
  localparam int T_GAP_NS    = 20;  // select and enable held inactive
  localparam int ACCESS_CYC  = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC     = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 4;
  // the read sample waits for the two synchroniser stages as well
  localparam logic [CNT_W-1:0] PULSE_LD =
    CNT_W'(ACCESS_CYC + SYNC_STAGES - 1);
  localparam logic [CNT_W-1:0] GAP_LD   = CNT_W'(GAP_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  // -------------------------------------------------------------------------
  // commands and controller states
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_CLAIM   = 2'b00,
    CMD_RELEASE = 2'b01,
    CMD_READ    = 2'b10,
    CMD_INIT    = 2'b11
  } cmd_e;

  typedef enum logic [2:0] {
    ST_BOOT  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b011,
    ST_GAP   = 3'b100
  } state_e;

  // -------------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    cmd_e             op;
    logic [IDX_W-1:0] idx;
  } cmd_s;

  typedef struct packed {
    logic              flag_space_select_n;
    logic              array_select_n;
    logic              oe_n;
    logic              rw_n;
    logic [IDX_W-1:0]  flag_index_lines;
    logic [DATA_W-1:0] data_out;
    logic              data_oe;
  } pins_s;

  typedef struct packed {
    state_e           st;
    logic [CNT_W-1:0] cnt;
    cmd_e             op;
    logic             last_rd;
    logic             failed;
    pins_s            pins;
    logic             ready;
    logic             done;
    logic             granted;
    logic             flag;
  } ctl_s;

  localparam pins_s PINS_IDLE = '{
    flag_space_select_n: 1'b1,
    array_select_n:      1'b1,
    oe_n:                1'b1,
    rw_n:                1'b1,
    flag_index_lines:    3'h0,
    data_out:            8'h00,
    data_oe:             1'b0
  };

  localparam ctl_s CTL_RESET = '{
    st:      ST_BOOT,
    cnt:     4'h0,
    op:      CMD_INIT,
    last_rd: 1'b0,
    failed:  1'b0,
    pins:    PINS_IDLE,
    ready:   1'b0,
    done:    1'b0,
    granted: 1'b0,
    flag:    1'b1
  };

endpackage

// ===== sem_sync2.sv
// two-stage synchroniser for the flag-space data pins
// assumes: inputs are asynchronous pins, output read on i_clk only
`timescale 1ns/1ps
module sem_sync2 #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // -------------------------------------------------------------------------
  // two flops; the first is read by the second only
  // -------------------------------------------------------------------------
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge i_clk) begin
    meta_reg <= i_async;
    sync_reg <= meta_reg;
  end

  assign o_sync = sync_reg;

endmodule

// ===== sem_flag_model.sv
// behavioural model of the dual-port flag space: eight flags, two ports
// assumes: port 0 faces the host controller, port 1 is driven by the bench
`timescale 1ns/1ps
module sem_flag_model (
  input  wire logic       i_sel_n,
  input  wire logic       i_arr_n,
  input  wire logic       i_oe_n,
  input  wire logic       i_rw_n,
  input  wire logic [2:0] i_idx,
  input  wire logic [7:0] i_d,
  output logic      [7:0] o_q,
  input  wire logic       i_r_sel_n,
  input  wire logic       i_r_oe_n,
  input  wire logic       i_r_rw_n,
  input  wire logic [2:0] i_r_idx,
  input  wire logic [7:0] i_r_d,
  output logic      [7:0] o_r_q
);
  // -------------------------------------------------------------------------
  // request latches and ownership, one row per port
  // -------------------------------------------------------------------------
  logic [1:0][7:0] req;   // 0 = request pending, eight flags
  logic [1:0][7:0] own;
  logic [1:0][2:0] widx;
  logic [1:0]      wval;
  logic [1:0][7:0] q;
  // strobes decoded sram-style, array select must stay high
  wire  [1:0] wr = {!i_r_sel_n && !i_r_rw_n, !i_sel_n && !i_rw_n && i_arr_n};
  wire  [1:0] rd = {!i_r_sel_n && !i_r_oe_n, !i_sel_n && !i_oe_n && i_arr_n};
  wire  [1:0][2:0] idx = {i_r_idx, i_idx};  // only three index lines
  wire  [1:0] d0 = {i_r_d[0], i_d[0]};  // only bit 0 is written

  // stale requests at power-up, right side holding every flag
  initial begin
    req = '0;
    own = {8'hff, 8'h00};
    q   = '0;
  end

  // flag update on the end of a write
  task automatic wr_flag(input int s, input logic [2:0] k, input logic v);
    req[s][k] = v;
    if (v && own[s][k]) begin
      own[s][k] = 1'b0;
      if (!req[1-s][k])
        own[1-s][k] = 1'b1;  // pending side takes over
    end else if (!v && !own[0][k] && !own[1][k]) begin
      own[s][k] = 1'b1;  // first write wins, later one waits
    end
    // a one from the non-owner only clears its request
  endtask

  for (genvar s = 0; s < 2; s++) begin : g_side
    // capture index and data once the write strobe settles
    always @(posedge wr[s]) begin
      #1;
      widx[s] = idx[s];
      wval[s] = d0[s];
    end
    always @(negedge wr[s]) begin
      if (!$isunknown({widx[s], wval[s]}))
        wr_flag(s, widx[s], wval[s]);
    end
    // read value frozen at start of read, spread on all bits
    always @(posedge rd[s]) begin
      logic v;
      #1;
      v = ~own[s][idx[s]];
      #14;
      q[s] = {8{v}};
    end
    // released bus shows the inverse of the last value
    always @(negedge rd[s]) begin
      q[s] = ~q[s];
    end
  end

  assign o_q   = q[0];
  assign o_r_q = q[1];
endmodule

// ===== dual_port_semaphore_flags_test.sv
// self-checking bench for the host flag-space controller
// assumes: sem_host drives port 0 of the model, bench drives port 1
`timescale 1ns/1ps
module dual_port_semaphore_flags_test;
  logic               i_clk;
  logic               i_srst;
  logic               i_cmd_valid;
  sem_host_pkg::cmd_s i_cmd;
  logic               o_cmd_ready;
  logic               o_done;
  logic               o_granted;
  logic               o_flag;
  logic               o_sel_n;
  logic               o_arr_n;
  logic               o_oe_n;
  logic               o_rw_n;
  logic [2:0]         o_idx;
  logic [7:0]         o_data;
  logic               o_data_oe;
  logic [7:0]         dev_q;
  logic [7:0]         pin_data;
  logic               r_sel_n;
  logic               r_oe_n;
  logic               r_rw_n;
  logic [2:0]         r_idx;
  logic [7:0]         r_d;
  logic [7:0]         r_q;
  int                 n_fail;
  int                 checked;
  logic               rq;
  logic [2:0]         k;

  // shared data pins: host drives during writes only
  assign pin_data = o_data_oe ? o_data : dev_q;

  sem_host i_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
    .o_granted(o_granted), .o_flag(o_flag),
    .o_flag_space_select_n(o_sel_n), .o_array_select_n(o_arr_n),
    .o_oe_n(o_oe_n), .o_rw_n(o_rw_n), .o_flag_index_lines(o_idx),
    .o_data(o_data), .o_data_oe(o_data_oe), .i_data(pin_data)
  );

  sem_flag_model i_model (
    .i_sel_n(o_sel_n), .i_arr_n(o_arr_n), .i_oe_n(o_oe_n), .i_rw_n(o_rw_n),
    .i_idx(o_idx), .i_d(pin_data), .o_q(dev_q), .i_r_sel_n(r_sel_n),
    .i_r_oe_n(r_oe_n), .i_r_rw_n(r_rw_n), .i_r_idx(r_idx), .i_r_d(r_d),
    .o_r_q(r_q)
  );

  // ---------------------------------------------------------------------------
  // clock, comparison and closing
  // ---------------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // pin monitor: array select idle, write data one bit replicated
  always @(negedge i_clk) begin
    if (!i_srst && o_sel_n === 1'b0) begin
      chk("array select", 8'h01, {7'h00, o_arr_n});
      if (o_rw_n === 1'b0)
        chk("write data", {8{o_data[0]}}, o_data);
    end
  end

  // ---------------------------------------------------------------------------
  // host command: wait ready, present one cycle, wait for done
  // ---------------------------------------------------------------------------
  task automatic hcmd(input sem_host_pkg::cmd_e op, input logic [2:0] ix);
    int n;
    n = 0;
    while (o_cmd_ready !== 1'b1 && n < 500) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd       <= '{op: op, idx: ix};
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_done !== 1'b1 && n < 200);
    chk("done seen", 8'h01, {7'h00, o_done});
  endtask

  // right port access, sram-style strobes held six cycles
  task automatic r_acc(input logic wr, input logic [2:0] ix, input logic v,
                       output logic q);
    @(posedge i_clk);
    r_sel_n <= 1'b0;
    r_rw_n  <= !wr;
    r_oe_n  <= wr;
    r_idx   <= ix;
    r_d     <= {7'($urandom), v};  // upper bits random
    repeat (6) @(posedge i_clk);
    q = r_q[0];
    if (!wr)
      chk("right read", {8{q}}, r_q);
    r_sel_n <= 1'b1;
    r_rw_n  <= 1'b1;
    r_oe_n  <= 1'b1;
    r_d     <= ~r_d;
    repeat (2) @(posedge i_clk);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    n_fail = 0;
    checked = 0;
    i_srst = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd = '0;
    r_sel_n = 1'b1;
    r_oe_n = 1'b1;
    r_rw_n = 1'b1;
    r_idx = 3'h0;
    r_d = 8'h00;
    void'($urandom(13208));
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    chk("ready in reset", 8'h00, {7'h00, o_cmd_ready});
    // right side clears its own stale requests
    for (int i = 0; i < 8; i++) r_acc(1'b1, 3'(i), 1'b1, rq);
    for (int it = 0; it < 8; it++) begin
      k = (it < 2) ? 3'(it * 7) : 3'($urandom % 8);
      hcmd(sem_host_pkg::CMD_CLAIM, k);
      chk("claim free", 8'h01, {7'h00, o_granted});
      r_acc(1'b0, k, 1'b0, rq);
      chk("right sees taken", 8'h01, {7'h00, rq});
      r_acc(1'b1, k, 1'b0, rq);
      r_acc(1'b0, k, 1'b0, rq);
      chk("pending reads one", 8'h01, {7'h00, rq});
      hcmd(sem_host_pkg::CMD_READ, k);
      chk("owner reads", 8'h00, {7'h00, o_flag});
      hcmd(sem_host_pkg::CMD_RELEASE, k);
      r_acc(1'b0, k, 1'b0, rq);
      chk("handover", 8'h00, {7'h00, rq});
      hcmd(sem_host_pkg::CMD_READ, k);
      chk("poll after pass", 8'h01, {7'h00, o_flag});
      hcmd(sem_host_pkg::CMD_CLAIM, k);
      chk("claim busy", 8'h00, {7'h00, o_granted});
      r_acc(1'b0, k, 1'b0, rq);
      chk("owner kept", 8'h00, {7'h00, rq});
      r_acc(1'b1, k, 1'b1, rq);
      hcmd(sem_host_pkg::CMD_READ, k);
      chk("freed", 8'h01, {7'h00, o_flag});
    end
    // both sides request one flag at nearly the same time
    for (int it = 0; it < 4; it++) begin
      k = 3'($urandom % 8);
      fork
        hcmd(sem_host_pkg::CMD_CLAIM, k);
        begin
          // early right writes win, late ones leave the host first
          repeat (it * 4) @(posedge i_clk);
          r_acc(1'b1, k, 1'b0, rq);
        end
      join
      r_acc(1'b0, k, 1'b0, rq);
      chk("one owner", 8'h01, {7'h00, o_granted ^ ~rq});
      if (o_granted === 1'b1)
        hcmd(sem_host_pkg::CMD_RELEASE, k);
      r_acc(1'b1, k, 1'b1, rq);
    end
    // host holds flag 5, init must hand it back
    hcmd(sem_host_pkg::CMD_CLAIM, 3'h5);
    chk("claim before init", 8'h01, {7'h00, o_granted});
    hcmd(sem_host_pkg::CMD_INIT, 3'h0);
    hcmd(sem_host_pkg::CMD_READ, 3'h5);
    chk("after init", 8'h01, {7'h00, o_flag});
    close_out();
  end

  // watchdog, well past the expected few thousand cycles
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule
